// ### logic/tcmu_consts.svh
// Constants for the timer compare match unit
`ifndef TCMU_CONSTS_SVH
`define TCMU_CONSTS_SVH

// Register byte offsets
`define TCMU_OFF_CTRL     8'h00
`define TCMU_OFF_CMPVAL   8'h04
`define TCMU_OFF_STATUS   8'h08
`define TCMU_OFF_COUNT    8'h0C
`define TCMU_OFF_EVCNT    8'h10

// Control register fields
`define TCMU_CTRL_MODE_LSB 0
`define TCMU_CTRL_MODE_MSB 3
`define TCMU_CTRL_TSEL     4
`define TCMU_CTRL_WIDTH    5

// Status register fields
`define TCMU_STAT_FLAG     0
`define TCMU_STAT_PIN      1

// Reset values
`define TCMU_RST_CTRL     5'h00
`define TCMU_RST_CMPVAL   16'h0000
`define TCMU_RST_EVCNT    16'h0000

// Mode select encodings
`define TCMU_MODE_SET     4'h8
`define TCMU_MODE_CLEAR   4'h9
`define TCMU_MODE_SWINT   4'hA
`define TCMU_MODE_SPECIAL 4'hB
`define TCMU_MODE_TOGGLE  4'h2

// AHB encodings
`define TCMU_HTRANS_NONSEQ 2'h2
`define TCMU_HTRANS_SEQ    2'h3
`define TCMU_HSIZE_WORD    3'h2

`endif

// ### logic/tcmu_pkg.sv
// Types for the timer compare match unit
package tcmu_pkg;

  typedef enum logic [1:0] {
    TCMU_PIN_LATCH  = 2'b00,
    TCMU_PIN_HIGH   = 2'b01,
    TCMU_PIN_LOW    = 2'b10,
    TCMU_PIN_TOGGLE = 2'b11
  } tcmu_pin_act_t;

endpackage

// ### logic/tcmu_cmp_reg.sv
// Compare value register with registered read port
`timescale 1ns/10ps
`default_nettype none
`include "tcmu_consts.svh"

module tcmu_cmp_reg #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output var  logic [WIDTH-1:0] value,
  output var  logic [WIDTH-1:0] rd_data
);

  // Stored word and registered copy for the bus read path
  always_ff @(posedge clk) begin
    if (rst) begin
      value   <= WIDTH'(`TCMU_RST_CMPVAL);
      rd_data <= WIDTH'(`TCMU_RST_CMPVAL);
    end else begin
      if (wr_en) begin
        value <= wr_data;
      end
      rd_data <= value;
    end
  end

endmodule
`default_nettype wire

// ### logic/tcmu_top.sv
// Timer compare match unit with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "tcmu_consts.svh"

module tcmu_top
  import tcmu_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output var  logic [31:0]   HRDATA,
  output var  logic          HREADYOUT,
  output var  logic          HRESP,
  input  wire logic [CW-1:0] FIRST_TIMER_COUNT,
  input  wire logic [CW-1:0] SECOND_TIMER_COUNT,
  input  wire logic          IO_LATCH,
  input  wire logic          PIN_DIRECTION_BIT,
  input  wire logic          ADC_ENABLED,
  output var  logic          COMPARE_OUTPUT_PIN,
  output var  logic          COMPARE_OUTPUT_OE,
  output var  logic          COMPARE_MATCH_FLAG,
  output var  logic          SPECIAL_TRIGGER,
  output var  logic          FIRST_TIMER_CLEAR,
  output var  logic          SECOND_TIMER_CLEAR,
  output var  logic          ADC_START
);

  // All state of the block apart from the compare value held in u_cmp
  typedef struct packed {
    logic [`TCMU_CTRL_WIDTH-1:0] ctrl;
    logic                        out_latch;
    logic                        flag;
    logic                        match_prev;
    logic [15:0]                 ev_count;
    logic                        trig;
    logic                        clr1;
    logic                        clr2;
    logic                        adc_go;
    logic                        pin;
    logic                        oe;
    logic                        dphase;
    logic                        dwrite;
    logic [7:0]                  daddr;
    logic [31:0]                 rdata;
  } tcmu_state_t;

  tcmu_state_t st_reg;
  tcmu_state_t st_next;

  logic [CW-1:0] cmp_value;
  logic          cmp_wr;
  logic [3:0]    mode;
  logic [CW-1:0] timebase;
  logic          match_now;
  logic          match_evt;
  tcmu_pin_act_t act;

  // Decode the mode field into a pin action
  function automatic tcmu_pin_act_t pin_action(input logic [3:0] m);
    case (m)
      `TCMU_MODE_SET:    pin_action = TCMU_PIN_HIGH;
      `TCMU_MODE_CLEAR:  pin_action = TCMU_PIN_LOW;
      `TCMU_MODE_TOGGLE: pin_action = TCMU_PIN_TOGGLE;
      default:           pin_action = TCMU_PIN_LATCH;
    endcase
  endfunction

  // True for any of the compare modes
  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == `TCMU_MODE_SET) || (m == `TCMU_MODE_CLEAR) ||
                 (m == `TCMU_MODE_TOGGLE) || (m == `TCMU_MODE_SWINT) ||
                 (m == `TCMU_MODE_SPECIAL);
  endfunction

  assign mode = st_reg.ctrl[`TCMU_CTRL_MODE_MSB:`TCMU_CTRL_MODE_LSB];
  assign act  = pin_action(mode);

  assign timebase  = st_reg.ctrl[`TCMU_CTRL_TSEL] ? SECOND_TIMER_COUNT
                                                  : FIRST_TIMER_COUNT;
  assign match_now = is_compare(mode) && (timebase == cmp_value);
  // One event per match; a timer held at the value does not refire
  assign match_evt = match_now && !st_reg.match_prev;

  // Compare value write strobe from the data phase
  assign cmp_wr = st_reg.dphase && st_reg.dwrite &&
                  (st_reg.daddr == `TCMU_OFF_CMPVAL);

  tcmu_cmp_reg #(
    .WIDTH (CW)
  ) u_cmp (
    .clk     (CLK),
    .rst     (RST),
    .wr_en   (cmp_wr),
    .wr_data (HWDATA[CW-1:0]),
    .value   (cmp_value),
    .rd_data ()
  );

  // Next-state logic: bus slave and compare actions
  always_comb begin
    logic flag_clr;
    logic addr_ok;
    flag_clr = 1'b0;
    addr_ok  = 1'b0;
    st_next  = st_reg;

    // Pulses last one cycle
    st_next.trig   = 1'b0;
    st_next.clr1   = 1'b0;
    st_next.clr2   = 1'b0;
    st_next.adc_go = 1'b0;
    st_next.match_prev = match_now;

    // Data phase: writes land, read data was captured in address phase
    if (st_reg.dphase && st_reg.dwrite) begin
      case (st_reg.daddr)
        `TCMU_OFF_CTRL: begin
          st_next.ctrl = HWDATA[`TCMU_CTRL_WIDTH-1:0];
          // Clearing the control word resets the compare latch low; a match event in the same cycle wins
          if (HWDATA[`TCMU_CTRL_WIDTH-1:0] == `TCMU_RST_CTRL) begin
            st_next.out_latch = 1'b0;
          end
        end
        `TCMU_OFF_STATUS: begin
          flag_clr = HWDATA[`TCMU_STAT_FLAG];
        end
        default: begin
        end
      endcase
    end

    // sticky flag, write one to clear
    if (flag_clr) begin
      st_next.flag = 1'b0;
    end

    if (match_evt) begin
      case (act)
        TCMU_PIN_HIGH:   st_next.out_latch = 1'b1;
        TCMU_PIN_LOW:    st_next.out_latch = 1'b0;
        TCMU_PIN_TOGGLE: st_next.out_latch = ~st_reg.out_latch;
        default:         st_next.out_latch = st_reg.out_latch;
      endcase
      // flag set on every match; set wins over clear
      st_next.flag     = 1'b1;
      st_next.ev_count = st_reg.ev_count + 16'h0001;
      if (mode == `TCMU_MODE_SPECIAL) begin
        st_next.trig = 1'b1;
        st_next.clr1 = !st_reg.ctrl[`TCMU_CTRL_TSEL];
        st_next.clr2 = st_reg.ctrl[`TCMU_CTRL_TSEL];
        st_next.adc_go = ADC_ENABLED;
      end
    end

    // pin reaches the pad only while direction bit is clear
    st_next.oe = !PIN_DIRECTION_BIT;
    // latch modes follow the ordinary I/O latch
    if (act == TCMU_PIN_LATCH) begin
      st_next.pin = IO_LATCH;
    end else begin
      st_next.pin = st_next.out_latch;
    end

    // Address phase capture
    addr_ok = HSEL && HREADY &&
              ((HTRANS == `TCMU_HTRANS_NONSEQ) ||
               (HTRANS == `TCMU_HTRANS_SEQ));
    st_next.dphase = addr_ok;
    st_next.dwrite = addr_ok && HWRITE;
    st_next.daddr  = HADDR[7:0];
    if (addr_ok && !HWRITE) begin
      case (HADDR[7:0])
        `TCMU_OFF_CTRL:
          st_next.rdata = {27'h000_0000, st_reg.ctrl};
        `TCMU_OFF_CMPVAL:
          st_next.rdata = {16'h0000, cmp_value};
        `TCMU_OFF_STATUS:
          st_next.rdata = {30'h0000_0000, st_reg.out_latch, st_reg.flag};
        `TCMU_OFF_COUNT:
          st_next.rdata = {16'h0000, timebase};
        `TCMU_OFF_EVCNT:
          st_next.rdata = {16'h0000, st_reg.ev_count};
        default:
          st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data straight from its register; no mux after the flop
  assign HRDATA = st_reg.rdata;
  // Zero wait states; response always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Outputs straight from the state register
  assign COMPARE_OUTPUT_PIN = st_reg.pin;
  assign COMPARE_OUTPUT_OE  = st_reg.oe;
  assign COMPARE_MATCH_FLAG = st_reg.flag;
  assign SPECIAL_TRIGGER    = st_reg.trig;
  assign FIRST_TIMER_CLEAR  = st_reg.clr1;
  assign SECOND_TIMER_CLEAR = st_reg.clr2;
  assign ADC_START          = st_reg.adc_go;

endmodule
`default_nettype wire

// ### tb/tcmu_top_props.sv
// Assertion checker for the timer compare match unit
`timescale 1ns/10ps
`default_nettype none
module tcmu_top_props #(
  parameter int CW = 16
) (
  input wire logic          CLK,
  input wire logic          RST,
  input wire logic [31:0]   HADDR,
  input wire logic [1:0]    HTRANS,
  input wire logic          HWRITE,
  input wire logic [31:0]   HWDATA,
  input wire logic [CW-1:0] FIRST_TIMER_COUNT,
  input wire logic [CW-1:0] SECOND_TIMER_COUNT,
  input wire logic          ADC_ENABLED,
  input wire logic          COMPARE_OUTPUT_PIN,
  input wire logic          COMPARE_MATCH_FLAG,
  input wire logic          SPECIAL_TRIGGER,
  input wire logic          FIRST_TIMER_CLEAR,
  input wire logic          SECOND_TIMER_CLEAR,
  input wire logic          ADC_START
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic          wa;
  logic [7:0]    ad;
  logic [3:0]    md;
  logic          sl;
  logic [CW-1:0] cv;
  logic          eq_q;
  wire  logic    eq = (sl ? SECOND_TIMER_COUNT : FIRST_TIMER_COUNT) == cv;
  // Only the first cycle of an equality run counts
  wire  logic    rise = eq && !eq_q;
  wire  logic    clr = wa && ad == 8'h08 && HWDATA[0];
  // Shadow of mode, select and compare value taken off the bus
  always_ff @(posedge CLK) begin
    if (RST) begin
      wa   <= 1'b0;
      md   <= 4'h0;
      sl   <= 1'b0;
      cv   <= '0;
      eq_q <= 1'b0;
    end else begin
      wa   <= HTRANS[1] && HWRITE;
      ad   <= HADDR[7:0];
      eq_q <= eq;
      if (wa && ad == 8'h00) begin
        md <= HWDATA[3:0];
        sl <= HWDATA[4];
      end
      if (wa && ad == 8'h04)
        cv <= HWDATA[CW-1:0];
    end
  end
  match_trig_a: assert property (
    rise && md == 4'hB |=> SPECIAL_TRIGGER) else $error("trigger missing");
  pin_set_a: assert property (
    rise && md[3:1] == 3'h4 |=> COMPARE_OUTPUT_PIN == !$past(md[0]))
    else $error("pin not set");
  pin_tog_a: assert property (
    rise && md == 4'h2 |=> COMPARE_OUTPUT_PIN != $past(COMPARE_OUTPUT_PIN))
    else $error("pin not toggled");
  flag_set_a: assert property (
    rise && md inside {4'h2, 4'h8, 4'h9, 4'hA, 4'hB} |=> COMPARE_MATCH_FLAG)
    else $error("flag not set");
  flag_only_a: assert property (
    rise && md == 4'hA |=> COMPARE_MATCH_FLAG && !SPECIAL_TRIGGER)
    else $error("flag only mode wrong");
  clear_sel_a: assert property (
    SPECIAL_TRIGGER || FIRST_TIMER_CLEAR || SECOND_TIMER_CLEAR |->
    SPECIAL_TRIGGER && SECOND_TIMER_CLEAR == sl && FIRST_TIMER_CLEAR == !sl)
    else $error("wrong timer cleared");
  adc_gate_a: assert property (
    SPECIAL_TRIGGER || ADC_START |->
    ADC_START == (SPECIAL_TRIGGER && $past(ADC_ENABLED)))
    else $error("conversion start wrong");
  flag_hold_a: assert property (
    COMPARE_MATCH_FLAG && !clr |=> COMPARE_MATCH_FLAG)
    else $error("flag dropped");
  cover property (rise && md == 4'hB);
  cover property (ADC_START);
  cover property ($fell(COMPARE_MATCH_FLAG));
endmodule
bind tcmu_top tcmu_top_props #(.CW(CW)) u_tcmu_top_props (
  .CLK(CLK), .RST(RST), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .FIRST_TIMER_COUNT(FIRST_TIMER_COUNT),
  .SECOND_TIMER_COUNT(SECOND_TIMER_COUNT), .ADC_ENABLED(ADC_ENABLED),
  .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN),
  .COMPARE_MATCH_FLAG(COMPARE_MATCH_FLAG), .SPECIAL_TRIGGER(SPECIAL_TRIGGER),
  .FIRST_TIMER_CLEAR(FIRST_TIMER_CLEAR),
  .SECOND_TIMER_CLEAR(SECOND_TIMER_CLEAR), .ADC_START(ADC_START));
`default_nettype wire

// ### tb/tcmu_timer_model.sv
// Model of the two timebase counters
`timescale 1ns/10ps
`default_nettype none
module tcmu_timer_model #(
  parameter logic [15:0] START2 = 16'h8000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        clr1,
  input  wire logic        clr2,
  output var  logic [15:0] cnt1,
  output var  logic [15:0] cnt2
);
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt1 <= 16'h0000;
      cnt2 <= START2;
    end else begin
      cnt1 <= clr1 ? 16'h0000 : cnt1 + 16'(run);
      cnt2 <= clr2 ? 16'h0000 : cnt2 + 16'(run);
    end
  end
endmodule
`default_nettype wire

// ### tb/test_timer_compare_match_unit.sv
// Self-checking bench for the timer compare match unit
`timescale 1ns/10ps
`default_nettype none
module test_timer_compare_match_unit;
  logic        clk = 0, rst = 1, hwrite = 0, run = 0, sel;
  logic        io_latch = 0, pdir = 1, adc_en = 0, rdy, pin, oe, flag;
  logic        trg, c1, c2, adcs, resp;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [15:0] cnt1, cnt2;
  int          errors = 0, num_checks = 0, n_trg = 0, n_adc = 0;
  int          n_c1 = 0, n_c2 = 0;
  logic [4:0]  cfg [7] = '{5'h08, 5'h09, 5'h02, 5'h02, 5'h0A, 5'h0B, 5'h1B};
  logic        pexp [7] = '{1, 0, 1, 0, 0, 1, 0};
  always #25 clk = ~clk;
  tcmu_top u_tcmu_top (
    .CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy),
    .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(resp), .FIRST_TIMER_COUNT(cnt1),
    .SECOND_TIMER_COUNT(cnt2), .IO_LATCH(io_latch), .PIN_DIRECTION_BIT(pdir),
    .ADC_ENABLED(adc_en), .COMPARE_OUTPUT_PIN(pin), .COMPARE_OUTPUT_OE(oe),
    .COMPARE_MATCH_FLAG(flag), .SPECIAL_TRIGGER(trg),
    .FIRST_TIMER_CLEAR(c1), .SECOND_TIMER_CLEAR(c2), .ADC_START(adcs));
  tcmu_timer_model u_tcmu_timer_model (
    .clk(clk), .rst(rst), .run(run), .clr1(c1), .clr2(c2),
    .cnt1(cnt1), .cnt2(cnt2));
  // Pulse tallies; one pulse per match is the point
  always @(posedge clk) begin
    n_trg += trg;
    n_adc += adcs;
    n_c1 += c1;
    n_c2 += c2;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One word transfer; the ready wait guards against a slow slave
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= 32'(a);
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    q = hrdata;
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pdir <= 1'b0;
    @(posedge clk);
    xfer(0, 8'h20, 0);
    chk(q, 0);
    chk(32'(resp), 0);
    chk(32'(oe), 1);
    // Timer frozen while configuring so no stray match
    for (int i = 0; i < 7; i++) begin
      sel = cfg[i][4];
      io_latch <= pexp[i];
      adc_en <= (i == 5);
      xfer(1, 8'h04, 32'((sel ? cnt2 : cnt1) + 16'h0005));
      xfer(1, 8'h00, 32'(cfg[i]));
      xfer(0, 8'h0C, 0);
      chk(q, 32'(sel ? cnt2 : cnt1));
      run <= 1'b1;
      repeat (10) @(posedge clk);
      run <= 1'b0;
      @(posedge clk);
      // Flag-only and trigger modes leave the I/O latch level on the pin
      chk(32'(pin), 32'(pexp[i]));
      chk(32'(flag), 1);
      xfer(0, 8'h08, 0);
      chk(32'(q[0]), 1);
      xfer(1, 8'h08, 1);
      xfer(0, 8'h08, 0);
      chk(32'(q[0]), 0);
      chk(32'(flag), 0);
    end
    // One counted event per pass, none from cleared timers
    xfer(0, 8'h10, 0);
    chk(q, 7);
    chk(n_trg, 2);
    chk(n_adc, 1);
    chk(n_c1, 1);
    chk(n_c2, 1);
    conclude();
  end
  // Watchdog well past the roughly 170 cycles of the sequence
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
